// *** logic/tmc_params.svh ***
// field positions, chain number and reset values of the trace scan access path
`ifndef TMC_PARAMS_SVH
`define TMC_PARAMS_SVH

`define TMC_SR_W       40
`define TMC_DATA_W     32
`define TMC_ADDR_W     7
`define TMC_DATA_MSB   31
`define TMC_DATA_LSB   0
`define TMC_ADDR_MSB   38
`define TMC_ADDR_LSB   32
`define TMC_RW_BIT     39
`define TMC_CHAIN_W    4
`define TMC_SCAN_CHAIN 4'h6
`define TMC_SR_RST     40'h00_0000_0000
`define TMC_DATA_RST   32'h0000_0000
`define TMC_ADDR_RST   7'h00

`endif

// *** logic/tmc_pkg.sv ***
// types shared by the trace scan access path
`include "tmc_params.svh"

package tmc_pkg;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE,
    TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPDATE_DR,
    TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR,
    TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPDATE_IR
  } tmc_tap_t;

  typedef struct packed {
    logic                   wr;
    logic [`TMC_ADDR_W-1:0] addr;
    logic [`TMC_DATA_W-1:0] data;
  } tmc_req_t;

endpackage : tmc_pkg

// *** logic/tmc_sync.sv ***
// two-flop synchroniser for signals arriving from outside the clock domain
`timescale 1ns/10ps

module tmc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         resetn,
  input  wire logic         ce,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = ce ? d : meta_q;
    sync_d = ce ? meta_q : sync_q;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign q = sync_q;

endmodule : tmc_sync

// *** logic/tmc_scan_access.sv ***
// scan-chain register access path of the trace macrocell, sampled from the test pins
`timescale 1ns/10ps
`include "tmc_params.svh"

// Summary of operation
// R1: registers reachable only via selected chain six
// R2: forty-bit shift register: data, address, flag
// R3: debugger writes: data, address, flag one
// R4: debugger reads: address, flag zero
// R5: read request ignores and drops data field
// R6: access fires only on entering Update-DR
// R7: data 31:0, address 38:32, flag 39, lsb-first
module tmc_scan_access
  import tmc_pkg::*;
(
  // system clock, reset, enable
  input  wire logic                    clock,
  input  wire logic                    resetn,
  input  wire logic                    ce,
  // test pins
  input  wire logic                    tck,
  input  wire logic                    tms,
  input  wire logic                    tdi,
  output logic                         tdo,
  output logic                         tdo_oe,
  // chain number held by the core's test controller
  input  wire logic [`TMC_CHAIN_W-1:0] chain_sel,
  // trace register port
  output tmc_req_t                     req,
  output logic                         req_wr,
  output logic                         req_rd,
  input  wire logic [`TMC_DATA_W-1:0]  rdata
);

  localparam int SW = 3 + `TMC_CHAIN_W;

  logic [SW-1:0]             pins_s;
  logic                      tck_s;
  logic                      tms_s;
  logic                      tdi_s;
  logic [`TMC_CHAIN_W-1:0]   chain_s;
  logic                      tck_prev_q;
  logic                      tck_rise;
  logic                      tck_fall;
  logic                      sel;
  tmc_tap_t                  tap_q;
  tmc_tap_t                  tap_d;
  logic [`TMC_SR_W-1:0]      shift_q;
  logic [`TMC_SR_W-1:0]      shift_d;
  logic [`TMC_DATA_W-1:0]    hold_q;
  logic [`TMC_DATA_W-1:0]    hold_d;
  tmc_req_t                  req_q;
  tmc_req_t                  req_d;
  logic                      wr_q;
  logic                      wr_d;
  logic                      rd_q;
  logic                      rd_d;
  logic                      tdo_q;
  logic                      tdo_d;

  // tck, tms and tdi share one synchroniser so their delays match
  tmc_sync #(
    .W (SW)
  ) u_sync (
    .clock  (clock),
    .resetn (resetn),
    .ce     (ce),
    .d      ({tck, tms, tdi, chain_sel}),
    .q      (pins_s)
  );

  assign tck_s    = pins_s[SW-1];
  assign tms_s    = pins_s[SW-2];
  assign tdi_s    = pins_s[SW-3];
  assign chain_s  = pins_s[`TMC_CHAIN_W-1:0];
  assign tck_rise = ce && tck_s && !tck_prev_q;
  assign tck_fall = ce && !tck_s && tck_prev_q;
  // R1: chain six gate
  assign sel      = (chain_s == `TMC_SCAN_CHAIN);

  function automatic tmc_tap_t tap_next(input tmc_tap_t s, input logic m);
    tmc_tap_t n;
    n = s;
    unique case (s)
      TAP_RESET:     n = m ? TAP_RESET     : TAP_IDLE;
      TAP_IDLE:      n = m ? TAP_SEL_DR    : TAP_IDLE;
      TAP_SEL_DR:    n = m ? TAP_SEL_IR    : TAP_CAP_DR;
      TAP_CAP_DR:    n = m ? TAP_EXIT1_DR  : TAP_SHIFT_DR;
      TAP_SHIFT_DR:  n = m ? TAP_EXIT1_DR  : TAP_SHIFT_DR;
      TAP_EXIT1_DR:  n = m ? TAP_UPDATE_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR:  n = m ? TAP_EXIT2_DR  : TAP_PAUSE_DR;
      TAP_EXIT2_DR:  n = m ? TAP_UPDATE_DR : TAP_SHIFT_DR;
      TAP_UPDATE_DR: n = m ? TAP_SEL_DR    : TAP_IDLE;
      TAP_SEL_IR:    n = m ? TAP_RESET     : TAP_CAP_IR;
      TAP_CAP_IR:    n = m ? TAP_EXIT1_IR  : TAP_SHIFT_IR;
      TAP_SHIFT_IR:  n = m ? TAP_EXIT1_IR  : TAP_SHIFT_IR;
      TAP_EXIT1_IR:  n = m ? TAP_UPDATE_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR:  n = m ? TAP_EXIT2_IR  : TAP_PAUSE_IR;
      TAP_EXIT2_IR:  n = m ? TAP_UPDATE_IR : TAP_SHIFT_IR;
      TAP_UPDATE_IR: n = m ? TAP_SEL_DR    : TAP_IDLE;
    endcase
    return n;
  endfunction : tap_next

  // follows the core's controller; five tms-high edges always land in reset
  always_comb begin
    tap_d = tap_q;
    if (tck_rise) begin
      tap_d = tap_next(tap_q, tms_s);
    end
  end

  always_comb begin
    shift_d = shift_q;
    hold_d  = hold_q;
    req_d   = req_q;
    wr_d    = 1'b0;
    rd_d    = 1'b0;
    tdo_d   = tdo_q;
    // read answer is taken in the strobe cycle itself
    if (ce && rd_q) begin
      hold_d = rdata;
    end
    if (tck_rise && sel) begin
      unique case (tap_q)
        // R7: capture read result into data field
        TAP_CAP_DR: shift_d[`TMC_DATA_MSB:`TMC_DATA_LSB] = hold_q;
        // R7: lsb first, tdi enters at bit 39
        TAP_SHIFT_DR: shift_d = {tdi_s, shift_q[`TMC_SR_W-1:1]};
        default: ;
      endcase
      // R6: act only on entry to update-dr
      if (tap_d == TAP_UPDATE_DR) begin
        // R2: split word into flag, address, data
        req_d.wr   = shift_q[`TMC_RW_BIT];
        req_d.addr = shift_q[`TMC_ADDR_MSB:`TMC_ADDR_LSB];
        req_d.data = shift_q[`TMC_DATA_MSB:`TMC_DATA_LSB];
        wr_d       = shift_q[`TMC_RW_BIT];
        rd_d       = !shift_q[`TMC_RW_BIT];
        // R5: read drops the shifted data
        if (!shift_q[`TMC_RW_BIT]) begin
          req_d.data = `TMC_DATA_RST;
        end
      end
    end
    // tdo moves on the falling edge so the debugger samples it settled
    if (tck_fall && sel && tap_q == TAP_SHIFT_DR) begin
      tdo_d = shift_q[0];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tck_prev_q <= 1'b0;
      tap_q      <= TAP_RESET;
      shift_q    <= `TMC_SR_RST;
      hold_q     <= `TMC_DATA_RST;
      req_q      <= '0;
      wr_q       <= 1'b0;
      rd_q       <= 1'b0;
      tdo_q      <= 1'b0;
    end else if (ce) begin
      tck_prev_q <= tck_s;
      tap_q      <= tap_d;
      shift_q    <= shift_d;
      hold_q     <= hold_d;
      req_q      <= req_d;
      wr_q       <= wr_d;
      rd_q       <= rd_d;
      tdo_q      <= tdo_d;
    end
  end

  assign req    = req_q;
  assign req_wr = wr_q;
  assign req_rd = rd_q;
  assign tdo    = tdo_q;
  // R1: drive tdo only for chain six
  assign tdo_oe = sel && (tap_q == TAP_SHIFT_DR);

  property p_upd_only;
    @(posedge clock) disable iff (!resetn)
      (wr_q || rd_q) |-> (tap_q == TAP_UPDATE_DR) && $past(sel) && !(wr_q && rd_q);
  endproperty
  a_upd_only: assert property (p_upd_only) else $error("access strobe outside update-dr"); // R6

  property p_split;
    @(posedge clock) disable iff (!resetn)
      (tck_rise && sel && tap_d == TAP_UPDATE_DR) |=>
        (wr_q == $past(shift_q[`TMC_RW_BIT])) &&
        (req_q.addr == $past(shift_q[`TMC_ADDR_MSB:`TMC_ADDR_LSB]));
  endproperty
  a_split: assert property (p_split) else $error("flag or address field misplaced"); // R2

  property p_read_drop;
    @(posedge clock) disable iff (!resetn)
      rd_q |-> (req_q.data == `TMC_DATA_RST) && !req_q.wr;
  endproperty
  a_read_drop: assert property (p_read_drop) else $error("read carried shifted data"); // R5

  property p_shift;
    @(posedge clock) disable iff (!resetn)
      (tck_rise && sel && tap_q == TAP_SHIFT_DR) |=>
        (shift_q[`TMC_RW_BIT] == $past(tdi_s)) &&
        (shift_q[`TMC_SR_W-2:0] == $past(shift_q[`TMC_SR_W-1:1]));
  endproperty
  a_shift: assert property (p_shift) else $error("shift not lsb first"); // R7

  property p_capture;
    @(posedge clock) disable iff (!resetn)
      (tck_rise && sel && tap_q == TAP_CAP_DR) |=>
        (shift_q[`TMC_DATA_MSB:`TMC_DATA_LSB] == $past(hold_q));
  endproperty
  a_capture: assert property (p_capture) else $error("read result not captured"); // R7

  property p_no_sel;
    @(posedge clock) disable iff (!resetn)
      !sel |-> !tdo_oe ##1 (!(wr_q || rd_q) && $stable(shift_q));
  endproperty
  a_no_sel: assert property (p_no_sel) else $error("activity with other chain selected"); // R1

  property p_tdo;
    @(posedge clock) disable iff (!resetn)
      (tck_fall && sel && tap_q == TAP_SHIFT_DR) |=> (tdo_q == $past(shift_q[0]));
  endproperty
  a_tdo: assert property (p_tdo) else $error("tdo not bit zero"); // R7

endmodule : tmc_scan_access

// *** test/tmc_dbg_model.sv ***
// behavioural test debugger that walks the tap and shifts scan words
`timescale 1ns/10ps

module tmc_dbg_model
  import tmc_pkg::*;
(
  // pacing clock
  input  wire logic clock,
  // test pins
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  initial begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h0;
  end

  // one 160 ns tck period; tdo read late in the high phase, well after it settles
  task automatic step(input logic m, input logic d, output logic o);
    tck <= 1'h0;
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge clock);
    tck <= 1'h1;
    repeat (4) @(posedge clock);
    o = tdo;
  endtask : step

  task automatic scan(input tmc_req_t w, output tmc_req_t got);
    logic o;
    @(posedge clock);
    step(1'h0, 1'h0, o);
    step(1'h1, 1'h0, o);
    step(1'h0, 1'h0, o);
    step(1'h0, 1'h0, o);
    for (int k = 0; k < 40; k++) begin
      step(k == 39, w[k], o);
      got[k] = o;
    end
    step(1'h1, 1'h0, o);
    step(1'h0, 1'h0, o);
    // tck stands low between frames
    tck <= 1'h0;
    @(posedge clock);
  endtask : scan
endmodule : tmc_dbg_model

// *** test/tb_top.sv ***
// self-checking bench for the trace scan access path
`timescale 1ns/10ps
`include "tmc_params.svh"

module tb_top;
  import tmc_pkg::*;

  localparam tmc_req_t WR1 = {1'h1, 7'h15, 32'hA5A5_0F0F};
  localparam tmc_req_t RD1 = {1'h0, 7'h2A, 32'hFFFF_FFFF};
  localparam tmc_req_t WR2 = {1'h1, 7'h7F, 32'h0000_0001};
  logic                    clock;
  logic                    resetn;
  logic                    ce;
  logic                    tck;
  logic                    tms;
  logic                    tdi;
  logic                    tdo;
  logic                    tdo_oe;
  logic [`TMC_CHAIN_W-1:0] chain_sel;
  tmc_req_t                req;
  logic                    req_wr;
  logic                    req_rd;
  logic [`TMC_DATA_W-1:0]  rdata;
  tmc_req_t                got;
  int                      fails;
  int                      n_checks;
  int                      n_wr;
  int                      n_rd;
  int                      n_oe;
  int                      w0;
  int                      r0;
  int                      o0;

  tmc_scan_access u_dut (.clock(clock), .resetn(resetn), .ce(ce), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .chain_sel(chain_sel), .req(req),
    .req_wr(req_wr), .req_rd(req_rd), .rdata(rdata));
  tmc_dbg_model u_dbg (.clock(clock), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

  always #10 clock = ~clock;

  // strobe cycles counted, so a wide pulse shows as more than one
  always @(posedge clock) begin
    n_wr += (req_wr === 1'h1);
    n_rd += (req_rd === 1'h1);
    n_oe += (tdo_oe === 1'h1);
  end

  task automatic check(input string what, input logic [39:0] exp, input logic [39:0] seen);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic run(input tmc_req_t w, input int ew, input int er, input int eo);
    w0 = n_wr;
    r0 = n_rd;
    o0 = n_oe;
    u_dbg.scan(w, got);
    check("wr strobes", 40'(ew), 40'(n_wr - w0));
    check("rd strobes", 40'(er), 40'(n_rd - r0));
    check("oe cycles", 40'(eo), 40'(n_oe - o0));
  endtask : run

  task automatic t_write();
    run(WR1, 1, 0, 320);
    check("write req", WR1, req);
    check("first capture", 40'h00_0000_0000, got);
  endtask : t_write

  task automatic t_read();
    @(posedge clock);
    rdata <= 32'h1234_5678;
    run(RD1, 0, 1, 320);
    check("read req", {1'h0, 7'h2A, 32'h0000_0000}, req);
    check("write echo", {1'h1, 7'h15, 32'h0000_0000}, got);
  endtask : t_read

  task automatic t_readback();
    run(WR2, 1, 0, 320);
    check("captured", {1'h0, 7'h2A, 32'h1234_5678}, got);
    check("write req", WR2, req);
  endtask : t_readback

  // frozen enable: a whole scan on the pins must leave no trace
  task automatic t_freeze();
    @(posedge clock);
    ce <= 1'h0;
    run(WR1, 0, 0, 0);
    check("req frozen", WR2, req);
    ce <= 1'h1;
  endtask : t_freeze

  task automatic t_other_chain();
    @(posedge clock);
    chain_sel <= 4'h5;
    run(WR1, 0, 0, 0);
    check("req kept", WR2, req);
    chain_sel <= 4'h6;
  endtask : t_other_chain

  initial begin
    clock = 1'h0;
    resetn = 1'h0;
    ce = 1'h1;
    chain_sel = 4'h6;
    rdata = 32'h0000_0000;
    repeat (5) @(posedge clock);
    resetn <= 1'h1;
    @(posedge clock);
    check("reset req", 40'h00_0000_0000, req);
    t_write();
    t_read();
    t_readback();
    t_freeze();
    t_other_chain();
    wrap_up();
  end

  initial begin
    #200us;
    fails++;
    wrap_up();
  end
endmodule : tb_top
